// ===== src/adc_conv_pkg.sv
// Shared constants and types for the parallel converter interface
package adc_conv_pkg;
   localparam int        RESULT_WIDTH     = 16;          // Result word width
   localparam int        HALF_WIDTH       = 8;           // Byte width for swapping
   localparam int        CLK_PERIOD_NS    = 100;         // Clock period
   localparam int        BUSY_DELAY_NS    = 83;          // Longest start-to-busy time
   localparam int        BUSY_DELAY_CYC   = (BUSY_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (BUSY_DELAY_NS / CLK_PERIOD_NS);
   localparam int        CONV_TIME_NS     = 4000;        // Conversion time
   localparam int        CONV_TIME_CYC    = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int        FIFO_DEPTH       = 8;           // Result buffer depth
   localparam logic [15:0] RESULT_RESET   = 16'h0000;    // Output register after reset

   // Converter sequencing states
   typedef enum logic [1:0] {IDLE, CONVERT, STORE} conv_state_type;

   // Raw control pins after synchronisation
   typedef struct packed {
      logic chipSelectN;
      logic readConvert;
      logic byteSwap;
   } ctrl_pins_type;
endpackage

// ===== src/result_fifo.sv
// Parameterised valid/ready FIFO for conversion results
`timescale 1ns/1ns
`default_nettype none
module result_fifo
   import adc_conv_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];            // Storage array
   logic [AW:0]      count;                  // Entries held
   logic [AW:0]      next_count;
   logic [AW-1:0]    wrPtr;                  // Write position
   logic [AW-1:0]    next_wrPtr;
   logic [AW-1:0]    rdPtr;                  // Read position
   logic [AW-1:0]    next_rdPtr;
   logic             next_inReady;           // Room left after this cycle
   logic             doWrite;
   logic             doRead;

   ////////////////////////////////////////////////////////////////
   // Handshake flags and pointer updates
   always_comb begin
      outValid   = (count != '0);
      outData    = mem[rdPtr];
      doWrite    = inValid && inReady;
      doRead     = outValid && outReady;
      next_wrPtr = doWrite ? AW'((wrPtr + 1'b1) % DEPTH) : wrPtr;
      next_rdPtr = doRead ? AW'((rdPtr + 1'b1) % DEPTH) : rdPtr;
      next_count = count + (AW+1)'(doWrite) - (AW+1)'(doRead);
      next_inReady = (next_count != (AW+1)'(DEPTH));
   end

   // Pointer and count registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count   <= '0;
         wrPtr   <= '0;
         rdPtr   <= '0;
         inReady <= 1'b1;
      end else begin
         inReady <= next_inReady;
         count <= next_count;
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
      end
   end

   // Storage write, no reset needed for data
   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule // result_fifo
`default_nettype wire

// ===== src/parallel_adc_conversion_interface.sv
// Conversion control and tri-state parallel read-out of a 16-bit converter
// Notes on behaviour
// - Data pins float when deselected or converting-low
// - Byte select low gives natural bit order
// - Byte select high swaps the two bytes
// - Convert falling edge with select low starts
// - Convert rising edge with select low drives
// - Select ORed with convert; select fall starts
// - Select fall with convert high drives bus
// - Busy low from start until result latched
// - Select tied low: data valid at busy rise
// - Busy falls within 83 ns of start; here busy falls about three clocks after the pin moves
// - Results are two's complement words
// - First result after power-up is indeterminate
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////
// Timing overview
// - Select, convert and byte pins are asynchronous; each passes two
//   flip-flops, so the block reacts about three clocks after a pin moves.
// - A start is the fall of the combined select-OR-convert level; starts
//   that arrive while a conversion runs are ignored.
// - Busy falls one clock after the start is seen and rises on the same
//   edge that latches the new word into the output register.
// - The bus word is formed from the value being latched, so the pins
//   already carry the new result when busy rises.
// - The output enable is a registered level; it opens on entering the
//   read stance and closes as soon as select rises or convert falls.
// - Conversion length is a parameter in clock cycles; the result waits
//   in STORE until the analog core has offered a sample.
module parallel_adc_conversion_interface
   import adc_conv_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_TIME_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    chipSelectN,
   input  wire logic                    readConvert,
   input  wire logic                    byteSelect,
   input  wire logic [RESULT_WIDTH-1:0] sampleCode,
   input  wire logic                    sampleValid,
   output logic                         sampleReady,
   output logic      [RESULT_WIDTH-1:0] dataOut,
   output logic      [RESULT_WIDTH-1:0] dataOe,
   output logic                         busyN,
   output logic                         firstResult
);
   ////////////////////////////////////////////////////////////////
   // Pin synchronisers
   ctrl_pins_type    syncA;                  // First stage, read only by syncB
   ctrl_pins_type    syncB;                  // Second stage
   ctrl_pins_type    prevPins;               // Previous synchronised value
   logic             convLow;                // High while select-OR-convert is low; its rise starts
   logic             prevConvLow;
   logic             startEvent;             // Combined signal fell
   logic             readEvent;              // Output enable opening

   // Two-stage synchronisers plus one stage of history for edge detection
   // Reset values match the idle pin levels so no false edge follows reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncA       <= '{chipSelectN: 1'b1, readConvert: 1'b1, byteSwap: 1'b0};
         syncB       <= '{chipSelectN: 1'b1, readConvert: 1'b1, byteSwap: 1'b0};
         prevPins    <= '{chipSelectN: 1'b1, readConvert: 1'b1, byteSwap: 1'b0};
         prevConvLow <= 1'b0;
      end else begin
         syncA       <= '{chipSelectN: chipSelectN, readConvert: readConvert, byteSwap: byteSelect};
         syncB       <= syncA;
         prevPins    <= syncB;
         prevConvLow <= convLow;
      end
   end

   // Edge decode on synchronised pins
   always_comb begin
      convLow    = !(syncB.chipSelectN | syncB.readConvert);
      startEvent = convLow && !prevConvLow;
      // Read stance entered: select low with convert high, not so last cycle
      readEvent  = !syncB.chipSelectN && syncB.readConvert &&
                   (prevPins.chipSelectN || !prevPins.readConvert);
   end

   ////////////////////////////////////////////////////////////////
   // Conversion sequencer
   conv_state_type          state;
   conv_state_type          next_state;
   logic [15:0]             convCount;       // Cycles left in conversion
   logic [15:0]             next_convCount;
   logic [RESULT_WIDTH-1:0] resultReg;       // Latched output register
   logic [RESULT_WIDTH-1:0] next_resultReg;
   logic                    next_busyN;
   logic                    firstDone;       // A result has been latched
   logic                    next_firstDone;
   logic                    next_firstResult;
   logic [RESULT_WIDTH-1:0] fifoData;
   logic                    fifoValid;
   logic                    fifoReady;

   // Analog samples buffered ahead of the output register
   result_fifo #(.WIDTH(RESULT_WIDTH), .DEPTH(FIFO_DEPTH)) sampleBuffer (
      .clk      (clk),
      .rst      (rst),
      .inData   (sampleCode),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoReady)
   );

   // Next-state logic for conversion
   // IDLE waits for a start, CONVERT counts down, STORE latches a sample
   always_comb begin
      next_state       = state;
      next_convCount   = convCount;
      next_resultReg   = resultReg;
      next_busyN       = busyN;
      next_firstDone   = firstDone;
      next_firstResult = firstResult;
      fifoReady        = 1'b0;
      unique case (state)
         IDLE: begin
            // Starts are only honoured while idle
            if (startEvent) begin
               next_state     = CONVERT;
               next_convCount = 16'(CONV_CYCLES);
               next_busyN     = 1'b0;
            end
         end
         CONVERT: begin
            if (convCount > 16'h0001) begin
               // Still converting
               next_convCount = convCount - 16'h0001;
            end else begin
               // Count exhausted: go fetch the result
               next_state = STORE;
            end
         end
         STORE: begin
            // Wait for a held sample, then latch it and release busy
            // An empty buffer keeps busy low; the host simply waits longer
            if (fifoValid) begin
               fifoReady        = 1'b1;
               next_resultReg   = fifoData;
               next_busyN       = 1'b1;
               next_firstResult = !firstDone;
               next_firstDone   = 1'b1;
               next_state       = IDLE;
            end
         end
         default: begin
            // Unused state code: fall back to idle
            next_state = IDLE;
         end
      endcase
   end

   // Sequencer registers
   // Reset leaves busy high and the bus released
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state       <= IDLE;
         convCount   <= 16'h0000;
         resultReg   <= RESULT_RESET;
         busyN       <= 1'b1;
         firstDone   <= 1'b0;
         firstResult <= 1'b0;
      end else begin
         state       <= next_state;
         convCount   <= next_convCount;
         resultReg   <= next_resultReg;
         busyN       <= next_busyN;
         firstDone   <= next_firstDone;
         firstResult <= next_firstResult;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Output bus drive
   logic [RESULT_WIDTH-1:0] next_dataOut;
   logic [RESULT_WIDTH-1:0] next_dataOe;
   logic                    driveEnable;     // Bus enabled for reading
   logic                    next_driveEnable;

   // Enable closes on any non-read stance, opens on entering one
   always_comb begin
      next_driveEnable = driveEnable;
      if (syncB.chipSelectN || !syncB.readConvert) begin
         next_driveEnable = 1'b0;
      end else if (readEvent || driveEnable) begin
         next_driveEnable = 1'b1;
      end
      // Word follows the register being latched this cycle, so it is valid at busy rise
      if (syncB.byteSwap) begin
         // Byte select high: halves trade places
         next_dataOut = {next_resultReg[HALF_WIDTH-1:0], next_resultReg[RESULT_WIDTH-1:HALF_WIDTH]};
      end else begin
         // Byte select low: natural order
         next_dataOut = next_resultReg;
      end
      // Every data pin shares the one enable
      next_dataOe = {RESULT_WIDTH{next_driveEnable}};
   end

   // Bus drive registers
   // Registered so the pins change only on clock edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         driveEnable <= 1'b0;
         dataOut     <= 16'h0000;
         dataOe      <= 16'h0000;
      end else begin
         driveEnable <= next_driveEnable;
         dataOut     <= next_dataOut;
         dataOe      <= next_dataOe;
      end
   end
endmodule // parallel_adc_conversion_interface
`default_nettype wire

// ===== tb/adc_conv_checker_assertions.sv
// Port-level checks for the converter interface
`timescale 1ns/1ns
`default_nettype none
module adc_conv_checker
   import adc_conv_pkg::*;
#(parameter int CONV_CYCLES = CONV_TIME_CYC) (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic                    chipSelectN,
   input wire logic                    readConvert,
   input wire logic                    byteSelect,
   input wire logic [RESULT_WIDTH-1:0] sampleCode,
   input wire logic                    sampleValid,
   input wire logic                    sampleReady,
   input wire logic [RESULT_WIDTH-1:0] dataOut,
   input wire logic [RESULT_WIDTH-1:0] dataOe,
   input wire logic                    busyN,
   input wire logic                    firstResult
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] lowCount; // Cycles spent busy so far
   // Count busy cycles, cleared while idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) lowCount <= 8'h00;
      else lowCount <= busyN ? 8'h00 : lowCount + 8'h01;
   end
   property p_float; (chipSelectN || !readConvert)[*4] |-> dataOe == 16'h0000; endproperty
   a_float: assert property (p_float) else $error("bus driven while released");
   property p_drive; (!chipSelectN && readConvert)[*4] |-> dataOe == 16'hFFFF; endproperty
   a_drive: assert property (p_drive) else $error("bus not driven in read stance");
   property p_swap; (busyN && dataOe[0] && !byteSelect)[*4] ##1 (busyN && byteSelect)[*4]
      |-> {dataOut[7:0], dataOut[15:8]} == $past(dataOut, 4); endproperty
   a_swap: assert property (p_swap) else $error("bytes not swapped");
   property p_start; busyN && $fell(chipSelectN || readConvert) |-> ##[1:4] !busyN; endproperty
   a_start: assert property (p_start) else $error("start not flagged busy");
   property p_nostart; $fell(busyN) |-> !$past(chipSelectN || readConvert, 2); endproperty
   a_nostart: assert property (p_nostart) else $error("busy without start");
   property p_busymin; $rose(busyN) |-> int'(lowCount) >= CONV_CYCLES; endproperty
   a_busymin: assert property (p_busymin) else $error("busy released early");
   property p_stable; (busyN && $stable(byteSelect))[*5] |-> $stable(dataOut); endproperty
   a_stable: assert property (p_stable) else $error("result moved while idle");
   property p_first; $changed(firstResult) |-> $rose(busyN); endproperty
   a_first: assert property (p_first) else $error("first flag moved off latch");
   c_swap: cover property ((busyN && dataOe[0] && !byteSelect)[*4] ##1 (busyN && byteSelect)[*4]);
   c_stall: cover property (int'(lowCount) > CONV_CYCLES + 2);
   c_first: cover property ($rose(firstResult));
endmodule // adc_conv_checker
bind parallel_adc_conversion_interface adc_conv_checker #(.CONV_CYCLES(CONV_CYCLES)) checker_i (
   .clk(clk), .rst(rst), .chipSelectN(chipSelectN), .readConvert(readConvert), .byteSelect(byteSelect),
   .sampleCode(sampleCode), .sampleValid(sampleValid), .sampleReady(sampleReady), .dataOut(dataOut),
   .dataOe(dataOe), .busyN(busyN), .firstResult(firstResult));
`default_nettype wire

// ===== tb/adc_host_model.sv
// Host model: drives select, convert and byte pins, reads the bus
`timescale 1ns/1ns
`default_nettype none
module adc_host_model
   import adc_conv_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    busyN,
   input  wire logic [RESULT_WIDTH-1:0] dataOut,
   input  wire logic [RESULT_WIDTH-1:0] dataOe,
   output logic                         chipSelectN,
   output logic                         readConvert,
   output logic                         byteSelect,
   output logic      [RESULT_WIDTH-1:0] word,
   output var int                       got
);
   logic [RESULT_WIDTH-1:0] lastSeen = 16'h0000; // Last level on each pin
   logic                    prevBusyN = 1'b1;   // Busy at previous falling edge
   wire  [RESULT_WIDTH-1:0] busWire = (dataOut & dataOe) | (~lastSeen & ~dataOe); // Released pins flip
   initial begin
      chipSelectN = 1'b1;
      readConvert = 1'b1;
      byteSelect = 1'b0;
      word = 16'h0000;
   end
   // Take the word just after busy rises, mid-cycle when settled
   always @(negedge clk) begin
      lastSeen <= busWire;
      prevBusyN <= busyN;
      if (busyN === 1'b1 && prevBusyN === 1'b0) begin
         word <= busWire;
         got <= got + 1;
      end
   end
   // One conversion, started by convert or by select; pins held 3 cycles
   task automatic convert(input logic viaSelect, input logic swap);
      repeat (4) @(negedge clk);
      byteSelect = swap;
      repeat (4) @(negedge clk);
      if (viaSelect) begin
         chipSelectN = 1'b1;
         readConvert = 1'b0;
         repeat (3) @(negedge clk);
         chipSelectN = 1'b0;
      end else begin
         chipSelectN = 1'b0;
         repeat (3) @(negedge clk);
         readConvert = 1'b0;
      end
      repeat (3) @(negedge clk);
      readConvert = 1'b1;
   endtask
   // Move select and let it settle
   task automatic choose(input logic level);
      @(negedge clk) chipSelectN = level;
      repeat (4) @(negedge clk);
   endtask
endmodule // adc_host_model
`default_nettype wire

// ===== tb/parallel_adc_conversion_interface_test.sv
// Self-checking bench for the converter interface
`timescale 1ns/1ns
`default_nettype none
module parallel_adc_conversion_interface_test import adc_conv_pkg::*;;
   localparam int CONVS = 4; // Shortened conversion time
   logic clk = 1'b0, rst = 1'b1, sampleValid = 1'b0, first = 1'b1;
   logic sampleReady, busyN, firstResult, chipSelectN, readConvert, byteSelect;
   logic [RESULT_WIDTH-1:0] sampleCode = 16'h0000, dataOut, dataOe, word, e;
   logic [RESULT_WIDTH-1:0] expQ[$]; // Offered samples, oldest first
   int got, errors = 0, nChecks = 0, cycles = 0, seed = 24;
   parallel_adc_conversion_interface #(.CONV_CYCLES(CONVS)) dut (.clk(clk), .rst(rst),
      .chipSelectN(chipSelectN), .readConvert(readConvert), .byteSelect(byteSelect), .sampleCode(sampleCode),
      .sampleValid(sampleValid), .sampleReady(sampleReady), .dataOut(dataOut), .dataOe(dataOe),
      .busyN(busyN), .firstResult(firstResult));
   adc_host_model host (.clk(clk), .busyN(busyN), .dataOut(dataOut), .dataOe(dataOe), .chipSelectN(chipSelectN),
      .readConvert(readConvert), .byteSelect(byteSelect), .word(word), .got(got));
   initial forever #50 clk = ~clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] expVal);
      nChecks++;
      if (seen !== expVal) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, expVal);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d errors=%0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Offer random samples and note each one taken
   task automatic push(input int n);
      repeat (n) begin
         @(negedge clk);
         sampleCode = 16'($random(seed));
         sampleValid = 1'b1;
         while (sampleReady !== 1'b1) @(negedge clk);
         expQ.push_back(sampleCode);
         @(posedge clk);
      end
      @(negedge clk) sampleValid = 1'b0;
   endtask
   task automatic waitIdle();
      repeat (3) @(negedge clk);
      while (busyN !== 1'b1) @(negedge clk);
      repeat (2) @(negedge clk);
   endtask
   // Compare each captured word after the first with the oldest note
   always @(got) begin
      if (expQ.size() == 0) check(word, 'x); // No note left: always a mismatch
      else begin
         e = expQ.pop_front();
         if (byteSelect) e = {e[7:0], e[15:8]};
         if (first) check({15'h0000, firstResult}, 16'h0001);
         else begin
            check(word, e);
            check({15'h0000, firstResult}, 16'h0000);
         end
         first = 1'b0;
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      check(dataOe, 16'h0000);
      push(8);
      check({15'h0000, sampleReady}, 16'h0000); // Full buffer refuses
      for (int i = 0; i < 9; i++) begin
         host.convert(i[0], i[1]);
         if (i == 8) begin
            repeat (20) @(negedge clk);
            check({15'h0000, busyN}, 16'h0000);
            push(1);
         end
         waitIdle();
         check(dataOe, 16'hFFFF);
         host.choose(1'b1);
         check(dataOe, 16'h0000);
         host.choose(1'b0);
         check(dataOe, 16'hFFFF);
         check({15'h0000, busyN}, 16'h0001);
      end
      stop_test();
   end
endmodule // parallel_adc_conversion_interface_test
`default_nettype wire
